// ==== hw/avs_pkg.sv ====
// Purpose: shared constants and types for the a/v switch control decode block
// Assumes: serial control bytes numbered 1..7, one read status byte
// Notes: field positions are bit numbers inside an 8-bit control byte
package avs_pkg;

    // serial device address, 7-bit form of the 8-bit write address
    localparam logic [6:0] DEV_ADDR = 7'h48;

    // control byte indexes in a write frame
    localparam logic [3:0] IDX_ATTEN = 4'h1;
    localparam logic [3:0] IDX_TV_SRC = 4'h2;
    localparam logic [3:0] IDX_REC_SRC = 4'h3;
    localparam logic [3:0] IDX_BLANK = 4'h5;
    localparam logic [3:0] IDX_GAIN = 4'h7;
    localparam logic [3:0] IDX_LAST = 4'h7;
    localparam logic [3:0] IDX_OVER = 4'h8;

    // attenuation_and_silence fields
    localparam int ATT_ZC_GATE = 0;
    localparam int ATT_SILENCE = 1;
    localparam int ATT_FINE_LSB = 2;
    localparam int ATT_COARSE_LSB = 5;
    // tv_source_select / recorder_source_select field
    localparam int SRC_LSB = 0;
    // blank_aspect_logic_ctrl fields
    localparam int BLK_LOGIC = 0;
    localparam int BLK_ASPECT_LSB = 1;
    localparam int BLK_SEL_LSB = 3;
    // gain_mono_silence_ctrl fields
    localparam int GN_MONO_TV = 3;
    localparam int GN_MONO_REC = 4;
    localparam int GN_GAIN = 6;
    localparam int GN_SILENCE = 7;
    // sense_status fields
    localparam int ST_ASPECT_LSB = 0;
    localparam int ST_POD = 4;
    localparam int ST_ZC_SEEN = 5;

    // reset values
    localparam logic [2:0] RST_SRC = 3'h4;
    localparam logic [2:0] RST_BLANK_SEL = 3'h0;
    localparam logic [1:0] RST_ASPECT = 2'h0;
    localparam logic [2:0] RST_ATTEN = 3'h0;

    // overlay blank select codes
    localparam logic [2:0] BLK_HIGH = 3'h1;
    localparam logic [2:0] BLK_IN_A = 3'h2;
    localparam logic [2:0] BLK_IN_B = 3'h3;

    // sound source codes
    localparam logic [2:0] SRC_IN1 = 3'h0;
    localparam logic [2:0] SRC_IN2 = 3'h1;
    localparam logic [2:0] SRC_IN3 = 3'h3;

    typedef enum logic [1:0] {
        avs_asp_internal,
        avs_asp_wide,
        avs_asp_43
    } avs_aspect_t;

endpackage

// ==== hw/avs_sync.sv ====
// Purpose: two flip-flop synchroniser for a group of independent levels
// Assumes: each bit is a slow level or a pulse wider than two clocks
// Notes: first stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module avs_sync #(
    parameter int W = 1
) (
    input wire logic i_clk,          // destination clock
    input wire logic i_nrst,         // async reset, active low
    input wire logic [W-1:0] i_d,    // asynchronous levels
    output logic [W-1:0] o_q         // synchronised levels
);
    logic [W-1:0] meta_q;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_q <= '0;
            o_q <= '0;
        end else begin
            meta_q <= i_d;
            o_q <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ==== hw/avs_route.sv ====
// Purpose: decode a 3-bit sound source code into an input select and a mute
// Assumes: code held in a register of the caller
// Notes: purely combinational
`timescale 1ns/100ps
`default_nettype none
module avs_route (
    input wire logic [2:0] i_code,   // sound source code
    output logic [1:0] o_sel,        // 0 input one, 1 input two, 2 input three
    output logic o_mute              // output pair muted
);
    wire is_in1 = i_code == avs_pkg::SRC_IN1;
    wire is_in2 = i_code == avs_pkg::SRC_IN2;
    wire is_in3 = i_code == avs_pkg::SRC_IN3;

    // unused code and codes 4..7 mute the pair
    assign o_mute = !(is_in1 || is_in2 || is_in3);
    assign o_sel = is_in3 ? 2'h2 : (is_in2 ? 2'h1 : 2'h0);
endmodule
`default_nettype wire

// ==== hw/avs_switch_ctrl.sv ====
// Purpose: serial control slave and decode of audio/video switch settings
// Assumes: i_scl is the serial bus clock, used as the link clock domain
// Notes: control bytes cross to i_clk by toggle, status by a frozen snapshot
`timescale 1ns/100ps
`default_nettype none
module avs_switch_ctrl (
    input wire logic i_clk,                         // core clock
    input wire logic i_nrst,                        // async reset, active low
    input wire logic i_scl,                         // serial bus clock
    input wire logic i_sda,                         // serial data in
    output logic o_sda_o,                           // serial data drive level
    output logic o_sda_oe,                          // serial data pull low
    input wire logic i_overlay_blank_in_a,          // overlay blank input a
    input wire logic i_overlay_blank_in_b,          // overlay blank input b
    input wire logic [1:0] i_recorder_aspect_sense, // recorder aspect level
    input wire logic i_hardware_silence_pin,        // silence all audio
    input wire logic i_zero_cross,                  // zero crossing detect
    input wire logic i_power_ok,                    // digital supply detect
    output logic o_overlay_blank,                   // overlay blank output
    output logic [1:0] o_aspect_mode,               // aspect signal control
    output logic o_logic_out_o,                     // logic pin drive level
    output logic o_logic_out_oe,                    // logic pin sink enable
    output logic [1:0] o_tv_source,                 // tv stereo input select
    output logic [1:0] o_recorder_source,           // recorder input select
    output logic o_tv_out_mute,                     // tv, phono, mono muted
    output logic o_recorder_out_mute,               // recorder pair muted
    output logic [5:0] o_tv_atten_db,               // tv attenuation in dB
    output logic o_tv_gain_6db,                     // tv extra gain step
    output logic o_tv_mono,                         // tv mono mix
    output logic o_recorder_mono                    // recorder mono mix
);
    // ---------------- core side synchronisers ----------------
    logic scl_s;
    logic sda_s;
    logic blank_a_s;
    logic blank_b_s;
    logic [1:0] aspect_s;
    logic hw_sil_s;
    logic zc_s;
    logic pod_s;
    logic tog_s;
    logic wr_tog_q;

    avs_sync #(.W(2)) u_pin_sync (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_d({i_scl, i_sda}),
        .o_q({scl_s, sda_s})
    );

    avs_sync #(.W(7)) u_in_sync (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_d({i_overlay_blank_in_a, i_overlay_blank_in_b, i_recorder_aspect_sense,
              i_hardware_silence_pin, i_zero_cross, i_power_ok}),
        .o_q({blank_a_s, blank_b_s, aspect_s, hw_sil_s, zc_s, pod_s})
    );

    avs_sync #(.W(1)) u_tog_sync (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_d(wr_tog_q),
        .o_q(tog_s)
    );

    // ---------------- frame start and stop ----------------
    logic scl_p_q;
    logic sda_p_q;
    logic frame_rst_q;

    wire start_det = scl_s && scl_p_q && sda_p_q && !sda_s;
    wire stop_det = scl_s && scl_p_q && !sda_p_q && sda_s;
    // held from start or stop until the bus clock is seen low
    wire frame_rst_d = (start_det || stop_det) ? 1'b1 : (scl_s ? frame_rst_q : 1'b0);

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            frame_rst_q <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
            frame_rst_q <= frame_rst_d;
        end
    end

    // status snapshot frozen while a frame runs, so the link reads it stable
    logic zc_seen_q;
    logic [7:0] snap_q;
    wire [7:0] snap_d = {2'h0, zc_seen_q, pod_s, 2'h0, aspect_s};

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            snap_q <= 8'h00;
        end else if (frame_rst_q) begin
            snap_q <= snap_d;
        end
    end

    // ---------------- link side, clocked by the bus clock ----------------
    // released only while the bus clock is low, so no edge races it
    wire link_rst = !i_nrst || frame_rst_q;

    logic [3:0] bit_cnt_q;
    logic [3:0] byte_idx_q;
    logic [6:0] shift_q;
    logic hit_q;
    logic read_q;
    logic [7:0] wr_byte_q;
    logic [3:0] wr_idx_q;
    logic sda_oe_q;

    wire [7:0] rx_byte = {shift_q, i_sda};
    wire byte_done = bit_cnt_q == 4'h7;
    wire ack_slot = bit_cnt_q == 4'h8;
    wire addr_byte = byte_idx_q == 4'h0;
    wire data_ok = !addr_byte && byte_idx_q <= avs_pkg::IDX_LAST;
    wire wr_take = byte_done && hit_q && !read_q && data_ok;

    always_ff @(posedge i_scl or posedge link_rst) begin
        if (link_rst) begin
            bit_cnt_q <= 4'h0;
            byte_idx_q <= 4'h0;
            shift_q <= 7'h00;
        end else if (ack_slot) begin
            bit_cnt_q <= 4'h0;
            if (byte_idx_q != avs_pkg::IDX_OVER) begin
                byte_idx_q <= byte_idx_q + 4'h1;
            end
        end else begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            shift_q <= rx_byte[6:0];
        end
    end

    always_ff @(posedge i_scl or posedge link_rst) begin
        if (link_rst) begin
            hit_q <= 1'b0;
            read_q <= 1'b0;
        end else if (byte_done && addr_byte) begin
            hit_q <= rx_byte[7:1] == avs_pkg::DEV_ADDR;
            read_q <= rx_byte[0];
        end else if (ack_slot && read_q && !addr_byte && i_sda) begin
            hit_q <= 1'b0;
        end
    end

    // publish a finished control byte; data stays stable for nine bus clocks
    always_ff @(posedge i_scl or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_byte_q <= 8'h00;
            wr_idx_q <= 4'h0;
            wr_tog_q <= 1'b0;
        end else if (wr_take) begin
            wr_byte_q <= rx_byte;
            wr_idx_q <= byte_idx_q;
            wr_tog_q <= !wr_tog_q;
        end
    end

    wire [2:0] tx_pos = 3'h7 - bit_cnt_q[2:0];
    wire ack_low = ack_slot && hit_q && (addr_byte || (!read_q && data_ok));
    wire rd_low = !ack_slot && hit_q && read_q && !addr_byte && !snap_q[tx_pos];

    always_ff @(negedge i_scl or posedge link_rst) begin
        if (link_rst) begin
            sda_oe_q <= 1'b0;
        end else begin
            sda_oe_q <= ack_low || rd_low;
        end
    end

    assign o_sda_o = 1'b0;
    assign o_sda_oe = sda_oe_q;

    // ---------------- control registers, core clock ----------------
    logic tog_p_q;
    logic [2:0] fine_q;
    logic [2:0] coarse_q;
    logic zc_gate_q;
    logic silence_req_q;
    logic [2:0] tv_src_q;
    logic [2:0] rec_src_q;
    logic [2:0] blank_sel_q;
    logic [1:0] aspect_q;
    logic logic_q;
    logic gain_q;
    logic mono_tv_q;
    logic mono_rec_q;

    wire wr_evt = tog_s ^ tog_p_q;
    wire wr_att = wr_evt && wr_idx_q == avs_pkg::IDX_ATTEN;
    wire wr_tv = wr_evt && wr_idx_q == avs_pkg::IDX_TV_SRC;
    wire wr_rec = wr_evt && wr_idx_q == avs_pkg::IDX_REC_SRC;
    wire wr_blk = wr_evt && wr_idx_q == avs_pkg::IDX_BLANK;
    wire wr_gn = wr_evt && wr_idx_q == avs_pkg::IDX_GAIN;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tog_p_q <= 1'b0;
            fine_q <= avs_pkg::RST_ATTEN;
            coarse_q <= avs_pkg::RST_ATTEN;
            zc_gate_q <= 1'b0;
        end else begin
            tog_p_q <= tog_s;
            if (wr_att) begin
                fine_q <= wr_byte_q[avs_pkg::ATT_FINE_LSB +: 3];
                coarse_q <= wr_byte_q[avs_pkg::ATT_COARSE_LSB +: 3];
                zc_gate_q <= wr_byte_q[avs_pkg::ATT_ZC_GATE];
            end
        end
    end

    // the same silence bit sits in two bytes; the later write wins
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            silence_req_q <= 1'b0;
        end else if (wr_att) begin
            silence_req_q <= wr_byte_q[avs_pkg::ATT_SILENCE];
        end else if (wr_gn) begin
            silence_req_q <= wr_byte_q[avs_pkg::GN_SILENCE];
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tv_src_q <= avs_pkg::RST_SRC;
            rec_src_q <= avs_pkg::RST_SRC;
        end else begin
            if (wr_tv) begin
                tv_src_q <= wr_byte_q[avs_pkg::SRC_LSB +: 3];
            end
            if (wr_rec) begin
                rec_src_q <= wr_byte_q[avs_pkg::SRC_LSB +: 3];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            blank_sel_q <= avs_pkg::RST_BLANK_SEL;
            aspect_q <= avs_pkg::RST_ASPECT;
            logic_q <= 1'b0;
        end else if (wr_blk) begin
            blank_sel_q <= wr_byte_q[avs_pkg::BLK_SEL_LSB +: 3];
            aspect_q <= wr_byte_q[avs_pkg::BLK_ASPECT_LSB +: 2];
            logic_q <= wr_byte_q[avs_pkg::BLK_LOGIC];
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            gain_q <= 1'b0;
            mono_tv_q <= 1'b0;
            mono_rec_q <= 1'b0;
        end else if (wr_gn) begin
            gain_q <= wr_byte_q[avs_pkg::GN_GAIN];
            mono_tv_q <= wr_byte_q[avs_pkg::GN_MONO_TV];
            mono_rec_q <= wr_byte_q[avs_pkg::GN_MONO_REC];
        end
    end

    // ---------------- zero crossing gating ----------------
    logic zc_p_q;
    logic silence_q;
    logic [5:0] atten_q;

    wire zc_evt = zc_s && !zc_p_q;
    // volume and silence changes wait for a crossing while gated
    wire apply_now = !zc_gate_q || zc_evt;
    wire silence_d = apply_now ? silence_req_q : silence_q;
    wire [5:0] atten_d = apply_now ? {coarse_q, fine_q} : atten_q;
    // the flag clears while the gate bit is off; a crossing then does not set it
    wire zc_seen_d = zc_gate_q && (zc_evt || zc_seen_q);

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            zc_p_q <= 1'b0;
            silence_q <= 1'b0;
            atten_q <= 6'h00;
            zc_seen_q <= 1'b0;
        end else begin
            zc_p_q <= zc_s;
            silence_q <= silence_d;
            atten_q <= atten_d;
            zc_seen_q <= zc_seen_d;
        end
    end

    // ---------------- output decode ----------------
    logic [1:0] tv_sel;
    logic [1:0] rec_sel;
    logic tv_route_mute;
    logic rec_route_mute;

    avs_route u_tv_route (
        .i_code(tv_src_q),
        .o_sel(tv_sel),
        .o_mute(tv_route_mute)
    );

    avs_route u_rec_route (
        .i_code(rec_src_q),
        .o_sel(rec_sel),
        .o_mute(rec_route_mute)
    );

    // codes 0, 4..7 give low
    wire blank_d = (blank_sel_q == avs_pkg::BLK_HIGH) ? 1'b1 :
                   (blank_sel_q == avs_pkg::BLK_IN_A) ? blank_a_s :
                   (blank_sel_q == avs_pkg::BLK_IN_B) ? blank_b_s : 1'b0;
    wire avs_pkg::avs_aspect_t aspect_d = (aspect_q == 2'h0) ? avs_pkg::avs_asp_internal :
                                          (aspect_q == 2'h1) ? avs_pkg::avs_asp_wide :
                                          avs_pkg::avs_asp_43;
    wire tv_mute_d = hw_sil_s || tv_route_mute || silence_q;
    wire rec_mute_d = hw_sil_s || rec_route_mute;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_overlay_blank <= 1'b0;
            o_aspect_mode <= 2'h0;
            o_logic_out_oe <= 1'b0;
            o_tv_source <= 2'h0;
            o_recorder_source <= 2'h0;
        end else begin
            o_overlay_blank <= blank_d;
            o_aspect_mode <= aspect_d;
            o_logic_out_oe <= logic_q;
            o_tv_source <= tv_sel;
            o_recorder_source <= rec_sel;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_tv_out_mute <= 1'b1;
            o_recorder_out_mute <= 1'b1;
            o_tv_atten_db <= 6'h00;
            o_tv_gain_6db <= 1'b0;
            o_tv_mono <= 1'b0;
            o_recorder_mono <= 1'b0;
        end else begin
            o_tv_out_mute <= tv_mute_d;
            o_recorder_out_mute <= rec_mute_d;
            o_tv_atten_db <= atten_q;
            o_tv_gain_6db <= gain_q;
            o_tv_mono <= mono_tv_q;
            o_recorder_mono <= mono_rec_q;
        end
    end

    assign o_logic_out_o = 1'b0;
endmodule
`default_nettype wire

// ==== verif/avs_switch_ctrl_asserts.sv ====
// Purpose: port-level assertions for avs_switch_ctrl
// Assumes: i_scl rests high between frames
// Notes: idle counter tracks a quiet bus and a steady silence pin
`timescale 1ns/100ps
`default_nettype none
module avs_switch_ctrl_asserts (
    input wire logic i_clk, // core clock
    input wire logic i_nrst, // reset, active low
    input wire logic i_scl, // serial clock
    input wire logic i_hardware_silence_pin, // silence pin
    input wire logic o_sda_o, // data drive level
    input wire logic o_sda_oe, // data pull low
    input wire logic o_overlay_blank, // blank output
    input wire logic [1:0] o_aspect_mode, // aspect mode
    input wire logic o_logic_out_o, // logic pin level
    input wire logic o_logic_out_oe, // logic pin sink
    input wire logic [1:0] o_tv_source, // tv select
    input wire logic o_tv_out_mute, // tv mute
    input wire logic o_recorder_out_mute, // recorder mute
    input wire logic [5:0] o_tv_atten_db, // attenuation
    input wire logic o_tv_gain_6db, // gain step
    input wire logic o_tv_mono, // tv mono
    input wire logic o_recorder_mono // recorder mono
);
    logic [5:0] idle_q;
    logic [5:0] idle_d;
    logic hw_q;
    logic quiet;
    assign quiet = i_scl && (hw_q == i_hardware_silence_pin);
    assign idle_d = !quiet ? 6'h00 : ((idle_q == 6'h3f) ? idle_q : idle_q + 6'h01);
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            idle_q <= 6'h00;
            hw_q <= 1'b0;
        end else begin
            idle_q <= idle_d;
            hw_q <= i_hardware_silence_pin;
        end
    end
    default clocking dc @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    reset_dflt_a: assert property (
        $rose(i_nrst) |-> !o_overlay_blank && o_aspect_mode == 2'h0 && !o_tv_gain_6db
            && o_tv_out_mute && o_recorder_out_mute && o_tv_atten_db == 6'h00)
        else $error("outputs not at defaults after reset");
    hardware_silence_pin_a: assert property (
        i_hardware_silence_pin [*5] |-> o_tv_out_mute && o_recorder_out_mute)
        else $error("silence pin did not mute all audio");
    ack_edge_a: assert property (
        $changed(o_sda_oe) |-> !i_scl)
        else $error("data line changed while serial clock high");
    sda_quiet_a: assert property (
        idle_q >= 6'h18 |-> !o_sda_oe)
        else $error("data line pulled on an idle bus");
    od_drive_a: assert property (
        !o_sda_o && !o_logic_out_o)
        else $error("open-drain pin driven high");
    aspect_code_a: assert property (
        o_aspect_mode != 2'h3 && o_tv_source != 2'h3)
        else $error("undefined aspect or source select");
    cfg_idle_a: assert property (
        idle_q >= 6'h18 |-> $stable({o_aspect_mode, o_tv_source, o_tv_gain_6db,
            o_tv_mono, o_recorder_mono, o_logic_out_oe}))
        else $error("settings changed without a bus write");
    rec_idle_a: assert property (
        idle_q >= 6'h18 |-> $stable(o_recorder_out_mute))
        else $error("recorder mute moved without cause");
endmodule
bind avs_switch_ctrl avs_switch_ctrl_asserts u_avs_switch_ctrl_asserts (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_scl(i_scl),
    .i_hardware_silence_pin(i_hardware_silence_pin), .o_sda_o(o_sda_o),
    .o_sda_oe(o_sda_oe), .o_overlay_blank(o_overlay_blank), .o_aspect_mode(o_aspect_mode),
    .o_logic_out_o(o_logic_out_o), .o_logic_out_oe(o_logic_out_oe),
    .o_tv_source(o_tv_source), .o_tv_out_mute(o_tv_out_mute),
    .o_recorder_out_mute(o_recorder_out_mute), .o_tv_atten_db(o_tv_atten_db),
    .o_tv_gain_6db(o_tv_gain_6db), .o_tv_mono(o_tv_mono), .o_recorder_mono(o_recorder_mono));
`default_nettype wire

// ==== verif/avs_i2c_host.sv ====
// Purpose: serial bus host model for the switch control block
// Assumes: open-drain data line with pull-up, resolved by the bench
// Notes: clock stands high between frames, 160 ns period, gap slows low phase
`timescale 1ns/100ps
`default_nettype none
module avs_i2c_host (
    output logic o_scl, // serial clock
    output logic o_sda_oe, // pulls data low when high
    input wire logic i_sda // resolved data line
);
    int gap = 0;
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end
    task automatic bit_io(input logic v, output logic r);
        #(40 + gap);
        o_sda_oe = !v;
        #40;
        o_scl = 1'b1;
        #80;
        r = i_sda;
        o_scl = 1'b0;
    endtask
    task automatic start();
        #7.3;
        o_sda_oe = 1'b1;
        #80;
        o_scl = 1'b0;
    endtask
    task automatic put(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic get(output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            b[i] = r;
        end
        bit_io(1'b1, r);
    endtask
    task automatic stop();
        #40;
        o_sda_oe = 1'b1;
        #40;
        o_scl = 1'b1;
        #80;
        o_sda_oe = 1'b0;
        #80;
    endtask
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// Purpose: self-checking bench for the switch control block
// Assumes: every write frame carries all seven control bytes
// Notes: bench model predicts outputs and status from the control bytes
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic in_a = 1'b0, in_b = 1'b0, hw_pin = 1'b0, zc_in = 1'b0, pok = 1'b1;
    logic [1:0] sense = 2'h0;
    logic scl, host_oe, sda, sda_o, dut_oe, blank, lg_o, lg_oe;
    logic tv_mute, rec_mute, gain, tv_mono, rec_mono, ack, sil_app, zc_seen;
    logic [1:0] aspect, tv_src, rec_src;
    logic [5:0] atten, att_app;
    logic [7:0] c [1:7];
    logic [7:0] r;
    logic [31:0] rs = 32'h27eb;
    int fail_count = 0;
    int checks_done = 0;
    always #2.5 i_clk = ~i_clk;
    assign sda = !(host_oe || (dut_oe && !sda_o));
    avs_i2c_host u_avs_i2c_host (.o_scl(scl), .o_sda_oe(host_oe), .i_sda(sda));
    avs_switch_ctrl u_avs_switch_ctrl (.i_clk(i_clk), .i_nrst(i_nrst), .i_scl(scl),
        .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(dut_oe), .i_overlay_blank_in_a(in_a),
        .i_overlay_blank_in_b(in_b), .i_recorder_aspect_sense(sense),
        .i_hardware_silence_pin(hw_pin), .i_zero_cross(zc_in), .i_power_ok(pok),
        .o_overlay_blank(blank), .o_aspect_mode(aspect), .o_logic_out_o(lg_o),
        .o_logic_out_oe(lg_oe), .o_tv_source(tv_src), .o_recorder_source(rec_src),
        .o_tv_out_mute(tv_mute), .o_recorder_out_mute(rec_mute), .o_tv_atten_db(atten),
        .o_tv_gain_6db(gain), .o_tv_mono(tv_mono), .o_recorder_mono(rec_mono));
    function automatic logic [7:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs[7:0];
    endfunction
    function automatic logic mute_of(input logic [2:0] s);
        return !(s == 3'h0 || s == 3'h1 || s == 3'h3);
    endfunction
    task automatic settle(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic check_all();
        logic [2:0] bc;
        bc = c[5][5:3];
        chk(8'(blank), 8'(bc == 3'h1 || (bc == 3'h2 && in_a) || (bc == 3'h3 && in_b)), "blank");
        chk(8'(aspect), (c[5][2:1] == 2'h0) ? 8'h0 : (c[5][2] ? 8'h2 : 8'h1), "aspect");
        chk({6'h0, lg_o, lg_oe}, {7'h0, c[5][0]}, "logic pin");
        chk(8'(tv_mute), 8'(hw_pin | mute_of(c[2][2:0]) | sil_app), "tv mute");
        chk(8'(rec_mute), 8'(hw_pin | mute_of(c[3][2:0])), "rec mute");
        if (!mute_of(c[2][2:0])) chk(8'(tv_src), 8'(c[2][1] ? 2'h2 : c[2][1:0]), "tv src");
        if (!mute_of(c[3][2:0])) chk(8'(rec_src), 8'(c[3][1] ? 2'h2 : c[3][1:0]), "rec src");
        chk(8'(atten), 8'(att_app), "atten");
        chk({5'h0, gain, tv_mono, rec_mono}, {5'h0, c[7][6], c[7][3], c[7][4]}, "gain mono");
    endtask
    task automatic apply_req(input logic zc);
        sil_app = c[7][7];
        att_app = {c[1][7:5], 3'h0} + 6'(c[1][4:2]);
        zc_seen = zc;
    endtask
    task automatic write_frame();
        u_avs_i2c_host.start();
        u_avs_i2c_host.put(8'h90, ack);
        chk(8'(ack), 8'h1, "address ack");
        for (int i = 1; i <= 7; i++) begin
            u_avs_i2c_host.put(c[i], ack);
            chk(8'(ack), 8'h1, "data ack");
        end
        u_avs_i2c_host.stop();
        if (!c[1][0]) apply_req(1'b0);
        settle(30);
        check_all();
    endtask
    task automatic read_status();
        u_avs_i2c_host.start();
        u_avs_i2c_host.put(8'h91, ack);
        chk(8'(ack), 8'h1, "read ack");
        u_avs_i2c_host.get(r);
        u_avs_i2c_host.stop();
        chk(r, {2'h0, zc_seen, pok, 2'h0, sense}, "status");
        settle(8);
    endtask
    task automatic zero_cross();
        zc_in = 1'b1;
        settle(8);
        zc_in = 1'b0;
        if (c[1][0]) apply_req(1'b1);
        settle(8);
        check_all();
    endtask
    task automatic end_test(input string name);
        $display("test %s done: %0d checks, %0d mismatches", name, checks_done, fail_count);
    endtask
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #400000;
        fail_count++;
        $display("MISMATCH t=%0t run did not finish", $time);
        give_verdict();
    end
    initial begin
        for (int i = 1; i <= 7; i++) c[i] = 8'h00;
        c[2] = 8'h04;
        c[3] = 8'h04;
        apply_req(1'b0);
        repeat (8) @(posedge i_clk);
        #1;
        i_nrst = 1'b1;
        settle(4);
        check_all();
        read_status();
        end_test("defaults");
        for (int k = 0; k < 8; k++) begin
            c[1] = rnd() & 8'hfc;
            c[2] = (rnd() & 8'hf8) | 8'(k);
            c[3] = (rnd() & 8'hf8) | 8'(7 - k);
            c[4] = rnd();
            c[5] = {2'h0, 3'(k), 2'(k), k[0]};
            c[6] = rnd();
            c[7] = rnd() & 8'h58;
            write_frame();
            for (int j = 0; j < 2; j++) begin
                r = rnd();
                in_a = r[0];
                in_b = r[1];
                settle(8);
                check_all();
            end
        end
        end_test("decode");
        c[1] = 8'h20;
        c[2] = 8'h00;
        c[3] = 8'h01;
        c[7] = 8'h00;
        write_frame();
        c[1] = 8'h4f;
        c[7] = 8'h80;
        u_avs_i2c_host.gap = 120;
        write_frame();
        u_avs_i2c_host.gap = 0;
        read_status();
        zero_cross();
        read_status();
        c[1] = 8'h01;
        c[7] = 8'h00;
        write_frame();
        zero_cross();
        c[1] = 8'h00;
        c[7] = 8'h00;
        write_frame();
        hw_pin = 1'b1;
        settle(8);
        check_all();
        hw_pin = 1'b0;
        settle(8);
        check_all();
        end_test("hardware silence");
        c[1] = 8'h02;
        c[7] = 8'h80;
        write_frame();
        zero_cross();
        read_status();
        end_test("silence");
        for (int k = 0; k < 4; k++) begin
            sense = (k == 2) ? 2'h3 : 2'(k & 1);
            pok = k[0];
            settle(8);
            read_status();
        end
        u_avs_i2c_host.start();
        u_avs_i2c_host.put(8'h92, ack);
        chk(8'(ack), 8'h0, "foreign address");
        u_avs_i2c_host.put(8'h05, ack);
        chk(8'(ack), 8'h0, "ignored byte");
        u_avs_i2c_host.stop();
        settle(30);
        check_all();
        end_test("status and address");
        give_verdict();
    end
endmodule
`default_nettype wire
